/* File: core/rht_params.svh */
// Register offsets, field layout and reset values of the raster horizontal timing generator
`ifndef RHT_PARAMS_SVH
`define RHT_PARAMS_SVH

`define RHT_ADDR_W 32
`define RHT_CNT_W 11
`define RHT_OFS_VERT_CLOCK_WINDOW 32'h8003000c
`define RHT_OFS_HORZ_LINE_TOTAL 32'h80030010
`define RHT_OFS_HORZ_SYNC_WINDOW 32'h80030014
`define RHT_OFS_HORZ_ACTIVE_WINDOW 32'h80030018
`define RHT_OFS_HORZ_CLOCK_WINDOW 32'h8003001c
`define RHT_OFS_HORZ_BLANK_WINDOW 32'h8003022c
`define RHT_OFS_FRAME_LINE_TOTAL 32'h80030000
`define RHT_OFS_VERT_ACTIVE_WINDOW 32'h80030008
`define RHT_OFS_VERT_BLANK_WINDOW 32'h80030228
`define RHT_OFS_LINE_CARRY_VALUE 32'h8003003c
`define RHT_OFS_CONTROL 32'h80030240
`define RHT_OFS_STATUS 32'h80030244
`define RHT_START_LSB 0
`define RHT_STOP_LSB 16
`define RHT_REG_RESET 32'h00000000
`define RHT_CTRL_ENABLE_BIT 0

`endif

/* File: core/rht_pkg.sv */
// Types shared by the raster horizontal timing generator
package rht_pkg;
  typedef logic [10:0] rht_count_t;
  typedef logic [31:0] rht_word_t;
  typedef enum logic [1:0] {
    RHT_IDLE = 2'b01,
    RHT_RUN = 2'b10
  } rht_state_e;
endpackage

/* File: core/rht_raster_timing.sv */
// Raster horizontal timing generator with vertical carry, clock gating and register port
`include "rht_params.svh"
`timescale 1ns/100ps
`default_nettype none

module rht_raster_timing #(
  parameter int CNT_W = `RHT_CNT_W,
  parameter int PIX_W = 24
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [`RHT_ADDR_W-1:0] regAddr,
  input wire rht_pkg::rht_word_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output rht_pkg::rht_word_t regRdata,
  input wire logic pixelClkIn,
  input wire logic [PIX_W-1:0] pixelIn,
  output logic [PIX_W-1:0] pixelOut,
  output logic horzSyncN,
  output logic compositeBlankN,
  output logic activeVideo,
  output logic pixelClkOut,
  output logic lineStart
);
  import rht_pkg::*;

  // ==========================================================
  // Register file
  logic [CNT_W-1:0] horzTotal_ff, frameTotal_ff, line_carry_value_ff;
  logic [CNT_W-1:0] hSyncStart_ff, hSyncStop_ff, hActStart_ff, hActStop_ff;
  logic [CNT_W-1:0] hBlkStart_ff, hBlkStop_ff, hClkStart_ff, hClkStop_ff;
  logic [CNT_W-1:0] vClkStart_ff, vClkStop_ff, vActStart_ff, vActStop_ff;
  logic [CNT_W-1:0] vBlkStart_ff, vBlkStop_ff;
  logic enable_ff;
  logic [CNT_W-1:0] horzCount_ff, vertCount_ff;
  logic horzActive_ff, vertActive_ff, horzBlankN_ff, vertBlankN_ff;
  logic horzClkGate_ff, vertClkGate_ff;
  rht_state_e state_ff;

  function automatic logic [CNT_W-1:0] fieldStart(input rht_word_t w);
    fieldStart = w[`RHT_START_LSB +: CNT_W];
  endfunction

  function automatic logic [CNT_W-1:0] fieldStop(input rht_word_t w);
    fieldStop = w[`RHT_STOP_LSB +: CNT_W];
  endfunction

  function automatic rht_word_t pack(input logic [CNT_W-1:0] stop, input logic [CNT_W-1:0] start);
    pack = '0;
    pack[`RHT_STOP_LSB +: CNT_W] = stop;
    pack[`RHT_START_LSB +: CNT_W] = start;
  endfunction

  // Window flop: start sets, stop clears; stop wins if both equal, so an
  // equal pair yields an empty window rather than a stuck one
  function automatic logic window(input logic cur, input logic [CNT_W-1:0] cnt,
                                  input logic [CNT_W-1:0] start, input logic [CNT_W-1:0] stop);
    window = cur;
    if (cnt == start) begin
      window = 1'b1;
    end
    if (cnt == stop) begin
      window = 1'b0;
    end
  endfunction

  // Write decode: the full address must match, so a write to an unmapped
  // offset lands nowhere
  function automatic logic wrHit(input logic en, input logic [`RHT_ADDR_W-1:0] addr,
                                 input logic [`RHT_ADDR_W-1:0] ofs);
    wrHit = en && (addr == ofs);
  endfunction

  logic wrEn;
  assign wrEn = clkEn && regWr;

  // Byte lanes are not decoded; only whole-word writes are meaningful
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      horzTotal_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_HORZ_LINE_TOTAL)) begin
      horzTotal_ff <= fieldStart(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frameTotal_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_FRAME_LINE_TOTAL)) begin
      frameTotal_ff <= fieldStart(regWdata);
    end
  end

  // Carry point sets the skew between horizontal and vertical timing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_carry_value_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_LINE_CARRY_VALUE)) begin
      line_carry_value_ff <= fieldStart(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hSyncStart_ff <= '0;
      hSyncStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_HORZ_SYNC_WINDOW)) begin
      hSyncStart_ff <= fieldStart(regWdata);
      hSyncStop_ff <= fieldStop(regWdata);
    end
  end

  // Software keeps this five counts past the clock window when gating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hActStart_ff <= '0;
      hActStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_HORZ_ACTIVE_WINDOW)) begin
      hActStart_ff <= fieldStart(regWdata);
      hActStop_ff <= fieldStop(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hBlkStart_ff <= '0;
      hBlkStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_HORZ_BLANK_WINDOW)) begin
      hBlkStart_ff <= fieldStart(regWdata);
      hBlkStop_ff <= fieldStop(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hClkStart_ff <= '0;
      hClkStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_HORZ_CLOCK_WINDOW)) begin
      hClkStart_ff <= fieldStart(regWdata);
      hClkStop_ff <= fieldStop(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vClkStart_ff <= '0;
      vClkStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_VERT_CLOCK_WINDOW)) begin
      vClkStart_ff <= fieldStart(regWdata);
      vClkStop_ff <= fieldStop(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vActStart_ff <= '0;
      vActStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_VERT_ACTIVE_WINDOW)) begin
      vActStart_ff <= fieldStart(regWdata);
      vActStop_ff <= fieldStop(regWdata);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vBlkStart_ff <= '0;
      vBlkStop_ff <= '0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_VERT_BLANK_WINDOW)) begin
      vBlkStart_ff <= fieldStart(regWdata);
      vBlkStop_ff <= fieldStop(regWdata);
    end
  end

  // Clearing enable parks both counters at their totals until set again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_ff <= 1'b0;
    end else if (wrHit(wrEn, regAddr, `RHT_OFS_CONTROL)) begin
      enable_ff <= regWdata[`RHT_CTRL_ENABLE_BIT];
    end
  end

  // Reserved bits are zero here; software must not rely on that
  rht_word_t nxt_rdata;
  always_comb begin
    nxt_rdata = '0;
    unique case (regAddr)
      `RHT_OFS_HORZ_LINE_TOTAL: nxt_rdata = pack('0, horzTotal_ff);
      `RHT_OFS_FRAME_LINE_TOTAL: nxt_rdata = pack('0, frameTotal_ff);
      `RHT_OFS_LINE_CARRY_VALUE: nxt_rdata = pack('0, line_carry_value_ff);
      `RHT_OFS_HORZ_SYNC_WINDOW: nxt_rdata = pack(hSyncStop_ff, hSyncStart_ff);
      `RHT_OFS_HORZ_ACTIVE_WINDOW: nxt_rdata = pack(hActStop_ff, hActStart_ff);
      `RHT_OFS_HORZ_BLANK_WINDOW: nxt_rdata = pack(hBlkStop_ff, hBlkStart_ff);
      `RHT_OFS_HORZ_CLOCK_WINDOW: nxt_rdata = pack(hClkStop_ff, hClkStart_ff);
      `RHT_OFS_VERT_CLOCK_WINDOW: nxt_rdata = pack(vClkStop_ff, vClkStart_ff);
      `RHT_OFS_VERT_ACTIVE_WINDOW: nxt_rdata = pack(vActStop_ff, vActStart_ff);
      `RHT_OFS_VERT_BLANK_WINDOW: nxt_rdata = pack(vBlkStop_ff, vBlkStart_ff);
      `RHT_OFS_CONTROL: nxt_rdata = {31'h00000000, enable_ff};
      `RHT_OFS_STATUS: nxt_rdata = pack(vertCount_ff, horzCount_ff);
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (clkEn) begin
      regRdata <= regRd ? nxt_rdata : '0;
    end
  end

  // ==========================================================
  // Pixel clock input: three-stage sampler, edge once stages two and three agree
  logic [2:0] pclkSync_ff;
  logic pclkLevel_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pclkSync_ff <= 3'h0;
      pclkLevel_ff <= 1'b0;
    end else if (clkEn) begin
      pclkSync_ff <= {pclkSync_ff[1:0], pixelClkIn};
      if (pclkSync_ff[1] == pclkSync_ff[2]) begin
        pclkLevel_ff <= pclkSync_ff[2];
      end
    end
  end
  logic pixTick;
  assign pixTick = (pclkSync_ff[1] == pclkSync_ff[2]) && pclkSync_ff[2] && !pclkLevel_ff;

  // ==========================================================
  // Counters
  logic lineEnd, carry, step;
  assign step = clkEn && pixTick && (state_ff == RHT_RUN);
  assign lineEnd = (horzCount_ff == '0);
  assign carry = (horzCount_ff == line_carry_value_ff);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= RHT_IDLE;
    end else if (clkEn) begin
      unique case (state_ff)
        RHT_IDLE: state_ff <= enable_ff ? RHT_RUN : RHT_IDLE;
        RHT_RUN: state_ff <= enable_ff ? RHT_RUN : RHT_IDLE;
        default: state_ff <= RHT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      horzCount_ff <= '0;
    end else if (clkEn && state_ff == RHT_IDLE) begin
      horzCount_ff <= horzTotal_ff;
    end else if (step) begin
      horzCount_ff <= lineEnd ? horzTotal_ff : horzCount_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vertCount_ff <= '0;
    end else if (clkEn && state_ff == RHT_IDLE) begin
      vertCount_ff <= frameTotal_ff;
    end else if (step && carry) begin
      vertCount_ff <= (vertCount_ff == '0) ? frameTotal_ff : vertCount_ff - 1'b1;
    end
  end

  // ==========================================================
  // Horizontal and vertical windows, equality compares only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      horzSyncN <= 1'b1;
      horzActive_ff <= 1'b0;
      horzBlankN_ff <= 1'b0;
      horzClkGate_ff <= 1'b0;
    end else if (step) begin
      horzSyncN <= !window(!horzSyncN, horzCount_ff, hSyncStart_ff, hSyncStop_ff);
      horzActive_ff <= window(horzActive_ff, horzCount_ff, hActStart_ff, hActStop_ff);
      horzBlankN_ff <= window(horzBlankN_ff, horzCount_ff, hBlkStart_ff, hBlkStop_ff);
      horzClkGate_ff <= window(horzClkGate_ff, horzCount_ff, hClkStart_ff, hClkStop_ff);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vertActive_ff <= 1'b0;
      vertBlankN_ff <= 1'b0;
      vertClkGate_ff <= 1'b0;
    end else if (step) begin
      vertActive_ff <= window(vertActive_ff, vertCount_ff, vActStart_ff, vActStop_ff);
      vertBlankN_ff <= window(vertBlankN_ff, vertCount_ff, vBlkStart_ff, vBlkStop_ff);
      vertClkGate_ff <= window(vertClkGate_ff, vertCount_ff, vClkStart_ff, vClkStop_ff);
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compositeBlankN <= 1'b0;
      activeVideo <= 1'b0;
      pixelClkOut <= 1'b0;
      lineStart <= 1'b0;
    end else if (clkEn) begin
      compositeBlankN <= horzBlankN_ff & vertBlankN_ff;
      activeVideo <= horzActive_ff | vertActive_ff;
      // Follows the sampled pixel clock only inside both windows; parked low otherwise
      pixelClkOut <= pclkLevel_ff & horzClkGate_ff & vertClkGate_ff;
      lineStart <= step & lineEnd;
    end
  end

  // Pixel bus captured once per step, so it holds steady for a whole pixel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixelOut <= '0;
    end else if (step) begin
      pixelOut <= horzActive_ff ? pixelIn : '0;
    end
  end

endmodule
`default_nettype wire

/* File: tb/rht_assertions.sv */
// Port-level assertions for the raster horizontal timing generator
`timescale 1ns/100ps
`default_nettype none
module rht_assertions #(
  parameter int PIX_W = 24
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic regRd,
  input wire rht_pkg::rht_word_t regRdata,
  input wire logic pixelClkIn,
  input wire logic [PIX_W-1:0] pixelIn,
  input wire logic [PIX_W-1:0] pixelOut,
  input wire logic horzSyncN,
  input wire logic compositeBlankN,
  input wire logic activeVideo,
  input wire logic pixelClkOut,
  input wire logic lineStart
);
  import rht_pkg::*;
  logic [6:0] pixHist_ff;
  logic stepNear;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Step history: outputs may only move a few cycles after a sampled pixel edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixHist_ff <= '0;
    end else begin
      pixHist_ff <= {pixHist_ff[5:0], pixelClkIn};
    end
  end
  assign stepNear = |pixHist_ff[6:1];
  // ==========================================================
  // Properties
  property p_syncFall; $fell(horzSyncN) |-> stepNear; endproperty
  property p_syncRise; $rose(horzSyncN) |-> stepNear; endproperty
  property p_active; $changed(activeVideo) |-> stepNear; endproperty
  property p_blank; $changed(compositeBlankN) |-> stepNear; endproperty
  property p_pixClk; $rose(pixelClkOut) |-> stepNear; endproperty
  property p_line; lineStart |=> !lineStart [*8]; endproperty
  property p_pix; $changed(pixelOut) && pixelOut != '0 |-> pixelOut == $past(pixelIn); endproperty
  property p_reserved_bits; $past(regRd) |-> regRdata[31:27] == '0 && regRdata[15:11] == '0; endproperty
  property p_rdIdle; !$past(regRd) |-> regRdata == '0; endproperty
  a_syncFall: assert property (p_syncFall) else $error("sync fell away from a pixel step");
  a_syncRise: assert property (p_syncRise) else $error("sync rose away from a pixel step");
  a_active: assert property (p_active) else $error("active video moved off step");
  a_blank: assert property (p_blank) else $error("blank moved off step");
  a_pixClk: assert property (p_pixClk) else $error("pixel clock rose without input clock");
  a_line: assert property (p_line) else $error("line pulse too close");
  a_pix: assert property (p_pix) else $error("pixel out not captured input");
  a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bits not zero");
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  c_line: cover property (lineStart);
  c_sync: cover property ($fell(horzSyncN));
  c_pclk: cover property ($rose(pixelClkOut));
endmodule
bind rht_raster_timing rht_assertions #(.PIX_W(PIX_W)) u_chk (.clk(clk), .resetn(resetn), .regRd(regRd),
  .regRdata(regRdata), .pixelClkIn(pixelClkIn), .pixelIn(pixelIn), .pixelOut(pixelOut), .horzSyncN(horzSyncN),
  .compositeBlankN(compositeBlankN), .activeVideo(activeVideo), .pixelClkOut(pixelClkOut), .lineStart(lineStart));
`default_nettype wire

/* File: tb/rht_pixel_source.sv */
// Pixel source model: link clock and pixel data feeding the generator
`timescale 1ns/100ps
`default_nettype none
module rht_pixel_source (
  input wire logic run,
  output logic pixClk,
  output logic [23:0] pixData
);
  // Clock stands still low outside a run, so idle time makes no steps
  initial begin
    pixClk = 1'b0;
    pixData = 24'h000001;
    #3;
    forever begin
      #80;
      if (run) begin
        pixClk = ~pixClk;
        if (pixClk) begin
          pixData = {pixData[22:0], pixData[23] ^ pixData[22]};
        end
      end else begin
        pixClk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/rht_raster_timing_bench.sv */
// Self-checking bench for the raster horizontal timing generator
`include "rht_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module rht_raster_timing_bench;
  import rht_pkg::*;
  localparam int STEP = 16;
  localparam logic [31:0] MAP [7] = '{`RHT_OFS_VERT_CLOCK_WINDOW, `RHT_OFS_HORZ_LINE_TOTAL,
    `RHT_OFS_HORZ_SYNC_WINDOW, `RHT_OFS_HORZ_ACTIVE_WINDOW, `RHT_OFS_HORZ_CLOCK_WINDOW,
    `RHT_OFS_HORZ_BLANK_WINDOW, 32'h80030ffc};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] regAddr = '0;
  rht_word_t regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic clkEn = 1'b1;
  logic run = 1'b0;
  rht_word_t regRdata;
  rht_word_t got;
  logic pixClk, horzSyncN, compositeBlankN, activeVideo, pixelClkOut, lineStart, pclkPrev;
  logic [23:0] pixData, pixelOut;
  logic [31:0] lfsr = 32'h00000037;
  int bad_count = 0;
  int tests_run = 0;
  int syncLow, actHigh, blankHigh, pixNz, pclkRise, pulses, n;
  always #5 clk = ~clk;
  rht_pixel_source src (.run(run), .pixClk(pixClk), .pixData(pixData));
  rht_raster_timing dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pixelClkIn(pixClk), .pixelIn(pixData),
    .pixelOut(pixelOut), .horzSyncN(horzSyncN), .compositeBlankN(compositeBlankN), .activeVideo(activeVideo),
    .pixelClkOut(pixelClkOut), .lineStart(lineStart));
  // ==========================================================
  // Expectation helpers and bus tasks
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] win(input int s, input int e);
    return (32'(e) << 16) | 32'(s);
  endfunction
  // Line total has only a start field; window registers keep both 11-bit fields
  function automatic logic [31:0] expRead(input logic [31:0] a, input logic [31:0] d);
    return (a == `RHT_OFS_HORZ_LINE_TOTAL) ? (d & 32'h000007ff) : (d & 32'h07ff07ff);
  endfunction
  function automatic int span(input int s, input int e);
    return (s - e) * STEP;
  endfunction
  task automatic regWrite(input logic [31:0] a, input rht_word_t d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regRead(input logic [31:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 got = regRdata;
    @(posedge clk);
  endtask
  task automatic waitLine();
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (lineStart !== 1'b1 && n < 400);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      regRead(MAP[i]);
      `CHK("reset value", 32'h0, got)
    end
    for (int i = 0; i < 6; i++) begin
      lfsr = nextRand(lfsr);
      regWrite(MAP[i], lfsr);
      regRead(MAP[i]);
      `CHK("readback", expRead(MAP[i], lfsr), got)
    end
    // A write while the clock enable is low must not land
    clkEn <= 1'b0;
    regWrite(MAP[5], 32'h00000000);
    clkEn <= 1'b1;
    regRead(MAP[5]);
    `CHK("frozen write", expRead(MAP[5], lfsr), got)
    regWrite(`RHT_OFS_HORZ_LINE_TOTAL, 32'd19);
    regWrite(`RHT_OFS_HORZ_SYNC_WINDOW, win(15, 12));
    regWrite(`RHT_OFS_HORZ_CLOCK_WINDOW, win(10, 2));
    regWrite(`RHT_OFS_HORZ_ACTIVE_WINDOW, win(10 + 5, 2 + 5));
    regWrite(`RHT_OFS_HORZ_BLANK_WINDOW, win(15, 7));
    regWrite(`RHT_OFS_FRAME_LINE_TOTAL, 32'd3);
    regWrite(`RHT_OFS_VERT_CLOCK_WINDOW, win(3, 0));
    regWrite(`RHT_OFS_VERT_ACTIVE_WINDOW, 32'h0);
    regWrite(`RHT_OFS_VERT_BLANK_WINDOW, win(3, 0));
    regWrite(`RHT_OFS_LINE_CARRY_VALUE, 32'h0);
    regWrite(`RHT_OFS_CONTROL, 32'h1);
    run <= 1'b1;
    // Skip the first frame: window state before the first wrap is not defined
    repeat (5) waitLine();
    {syncLow, actHigh, blankHigh, pixNz, pclkRise, pulses} = '0;
    pclkPrev = pixelClkOut;
    for (int c = 0; c < 4 * 20 * STEP; c++) begin
      syncLow += int'(horzSyncN === 1'b0);
      actHigh += int'(activeVideo === 1'b1);
      blankHigh += int'(compositeBlankN === 1'b1);
      pixNz += int'(pixelOut !== '0);
      pclkRise += int'(pixelClkOut === 1'b1 && pclkPrev === 1'b0);
      pulses += int'(lineStart === 1'b1);
      pclkPrev = pixelClkOut;
      @(posedge clk);
      #1;
    end
    `CHK("line pulses", 4, pulses)
    `CHK("line wrap", 1'b1, lineStart)
    `CHK("sync low", 4 * span(15, 12), syncLow)
    `CHK("active", 4 * span(15, 7), actHigh)
    `CHK("pixel data", 4 * span(15, 7), pixNz)
    `CHK("blank", 3 * span(15, 7), blankHigh)
    `CHK("pixel clocks", 3 * 8, pclkRise)
    close_out();
  end
endmodule
`default_nettype wire
